// >>> verilog/pcfg_pkg.sv
// constants, layouts and types for the configuration header slice
// assumes a configuration access port already decoded to dword index and byte enables
package pcfg_pkg;

    // byte offsets, dword-aligned except 0x0e; the 16-bit registers share dword 0x0c
    localparam logic [7:0] PCFG_CLASS_OFS      = 8'h08;
    localparam logic [7:0] PCFG_TIMING_OFS     = 8'h0c;
    localparam logic [7:0] PCFG_HDR_OFS        = 8'h0e;

    localparam logic [7:0] PCFG_CATEGORY_VAL   = 8'h0c;
    localparam logic [7:0] PCFG_SUBCLASS_VAL   = 8'h00;
    localparam logic [7:0] PCFG_SWMODEL_VAL    = 8'h10;
    localparam logic [7:0] PCFG_SELFTEST_VAL   = 8'h00;
    localparam logic [7:0] PCFG_HDRTYPE_VAL    = 8'h00;
    localparam logic [15:0] PCFG_TIMING_RST    = 16'h0000;

    // field positions inside the dword at 0x0c
    localparam int PCFG_LINE_LSB    = 0;
    localparam int PCFG_LAT_LSB     = 8;
    localparam int PCFG_TEST_LSB    = 24;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [5:0] dword;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } pcfg_req_s;

    typedef enum logic [1:0] {
        PCFG_IDLE,
        PCFG_OWN,
        PCFG_EXPIRED
    } pcfg_tenure_e;

endpackage

// >>> verilog/pcfg_header.sv
// configuration header slice: classification, tenure limit, line length, header type
// assumes requests arrive synchronous to clock_i; initiator frame/grant are async pins
// Behaviour
// - the top classification byte always reads 0x0c, a serial bus controller.
// - the second classification byte always reads zero, naming the serial bus kind.
// - the programming-interface byte always reads 0x10.
// - the lowest classification byte is a fixed silicon step code.
// - an eight-bit read/write tenure limit sits in bits 15..8, counted in clocks.
// - as initiator the tenure counter restarts at zero on the frame start, then counts.
// - once the count reaches the limit unfinished, the transfer ends when grant drops.
// - an eight-bit read/write line length sits in bits 7..0 for line-based commands.
// - the self-test byte always reads zero.
// - the header-type byte always reads zero.
`timescale 1ns/1ps
`default_nettype none
module pcfg_header #(
    parameter logic [7:0] SILICON_STEP = 8'h27 // arbitrary value
) (
    input  wire logic               clock_i,
    input  wire logic               reset_i,
    input  wire pcfg_pkg::pcfg_req_s req_i,
    output logic [31:0]             rdata_o,
    output logic                    ack_o,
    input  wire logic               frame_start_i,
    input  wire logic               xfer_done_i,
    input  wire logic               grant_n_i,
    output logic                    tenure_stop_o,
    output logic [7:0]              line_length_setting_o
);

    logic [7:0] tenure_limit_ff;
    logic [7:0] line_length_setting_ff;
    logic [7:0] tenure_count_ff;
    logic [31:0] rdata_ff;
    logic       ack_ff;
    logic [1:0] frame_sync_ff;
    logic [1:0] done_sync_ff;
    logic [1:0] gnt_sync_ff;
    logic       frame_prev_ff;
    pcfg_pkg::pcfg_tenure_e state_ff;
    pcfg_pkg::pcfg_tenure_e nxt_state;

    function automatic logic hit(input logic [5:0] dw, input logic [7:0] ofs);
        hit = (dw == ofs[7:2]);
    endfunction

    wire hit_class  = hit(req_i.dword, pcfg_pkg::PCFG_CLASS_OFS);
    wire hit_timing = hit(req_i.dword, pcfg_pkg::PCFG_TIMING_OFS);
    wire wr_timing  = req_i.valid & req_i.write & hit_timing;
    wire frame_rise = frame_sync_ff[1] & ~frame_prev_ff;
    wire grant_lost = gnt_sync_ff[1];
    wire count_hit  = (tenure_count_ff >= tenure_limit_ff);
    // request qualifiers shared by the register logic and its checks
    wire       rd_req        = req_i.valid & ~req_i.write;
    wire       wr_class      = req_i.valid & req_i.write & hit_class;
    wire       wr_limit_en   = wr_timing & req_i.byte_en[pcfg_pkg::PCFG_LAT_LSB / 8];
    wire       wr_line_en    = wr_timing & req_i.byte_en[pcfg_pkg::PCFG_LINE_LSB / 8];
    wire [7:0] wr_limit_byte = req_i.wdata[pcfg_pkg::PCFG_LAT_LSB +: 8];
    wire [7:0] wr_line_byte  = req_i.wdata[pcfg_pkg::PCFG_LINE_LSB +: 8];
    wire       in_own        = (state_ff == pcfg_pkg::PCFG_OWN);
    wire       in_expired    = (state_ff == pcfg_pkg::PCFG_EXPIRED);

    wire [31:0] class_word = {pcfg_pkg::PCFG_CATEGORY_VAL, pcfg_pkg::PCFG_SUBCLASS_VAL,
                              pcfg_pkg::PCFG_SWMODEL_VAL, SILICON_STEP};
    wire [31:0] timing_word = {pcfg_pkg::PCFG_SELFTEST_VAL, pcfg_pkg::PCFG_HDRTYPE_VAL,
                               tenure_limit_ff, line_length_setting_ff};
    wire [31:0] read_word = hit_class ? class_word : (hit_timing ? timing_word : 32'h0000_0000);

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            tenure_limit_ff        <= pcfg_pkg::PCFG_TIMING_RST[15:8];
            line_length_setting_ff <= pcfg_pkg::PCFG_TIMING_RST[7:0];
        end else begin
            if (wr_limit_en) begin
                tenure_limit_ff <= wr_limit_byte;
            end
            if (wr_line_en) begin
                line_length_setting_ff <= wr_line_byte;
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_ff <= 32'h0000_0000;
            ack_ff   <= 1'b0;
        end else begin
            ack_ff <= req_i.valid;
            if (req_i.valid && !req_i.write) begin
                rdata_ff <= read_word;
            end
        end
    end

    // frame, done and grant come from bus pins
    // grant_n resets high so no grant is assumed before the pin settles
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            frame_sync_ff <= 2'b00;
            done_sync_ff  <= 2'b00;
            gnt_sync_ff   <= 2'b11;
            frame_prev_ff <= 1'b0;
        end else begin
            frame_sync_ff <= {frame_sync_ff[0], frame_start_i};
            done_sync_ff  <= {done_sync_ff[0], xfer_done_i};
            gnt_sync_ff   <= {gnt_sync_ff[0], grant_n_i};
            frame_prev_ff <= frame_sync_ff[1];
        end
    end

    // a limit of zero expires on the first owned cycle
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            pcfg_pkg::PCFG_IDLE: begin
                if (frame_rise) begin
                    nxt_state = pcfg_pkg::PCFG_OWN;
                end
            end
            pcfg_pkg::PCFG_OWN: begin
                if (done_sync_ff[1]) begin
                    nxt_state = pcfg_pkg::PCFG_IDLE;
                end else if (count_hit) begin
                    nxt_state = pcfg_pkg::PCFG_EXPIRED;
                end
            end
            pcfg_pkg::PCFG_EXPIRED: begin
                // end after grant removal
                // stop lasts one cycle; the initiator side must act on it at once
                if (done_sync_ff[1] || grant_lost) begin
                    nxt_state = pcfg_pkg::PCFG_IDLE;
                end
            end
            default: nxt_state = pcfg_pkg::PCFG_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_ff        <= pcfg_pkg::PCFG_IDLE;
            tenure_count_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            // the count parks at the limit, so it never wraps under a small limit
            // restart at frame start
            if (frame_rise) begin
                tenure_count_ff <= 8'h00;
            end else if (state_ff == pcfg_pkg::PCFG_OWN && !count_hit) begin
                tenure_count_ff <= tenure_count_ff + 8'h01;
            end
        end
    end

    assign rdata_o               = rdata_ff;
    assign ack_o                 = ack_ff;
    assign line_length_setting_o = line_length_setting_ff;
    // stop request while expired and grant gone
    assign tenure_stop_o = in_expired & grant_lost;

    class_read_a: assert property (@(posedge clock_i) disable iff (reset_i)
        rd_req && hit_class |=> rdata_o[31:8] == 24'h0c_0010)
        else $error("classification read wrong");

    subclass_zero_a: assert property (@(posedge clock_i) disable iff (reset_i)
        rd_req && hit_class |=> rdata_o[23:16] == 8'h00)
        else $error("subclass byte not zero");

    sw_model_a: assert property (@(posedge clock_i) disable iff (reset_i)
        rd_req && hit_class |=> rdata_o[15:8] == 8'h10)
        else $error("software model byte wrong");

    step_code_a: assert property (@(posedge clock_i) disable iff (reset_i)
        ack_o && $past(rd_req && hit_class) |-> rdata_o[7:0] == SILICON_STEP)
        else $error("silicon step code wrong");

    limit_write_a: assert property (@(posedge clock_i) disable iff (reset_i)
        wr_timing && req_i.byte_en[1] |=> tenure_limit_ff == $past(req_i.wdata[15:8]))
        else $error("tenure limit not stored");

    limit_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
        !wr_limit_en |=> tenure_limit_ff == $past(tenure_limit_ff))
        else $error("tenure limit changed without write");

    limit_read_a: assert property (@(posedge clock_i) disable iff (reset_i)
        rd_req && hit_timing |=> rdata_o[15:8] == $past(tenure_limit_ff))
        else $error("tenure limit read wrong");

    count_restart_a: assert property (@(posedge clock_i) disable iff (reset_i)
        frame_rise |=> tenure_count_ff == 8'h00)
        else $error("tenure count not restarted");

    count_step_a: assert property (@(posedge clock_i) disable iff (reset_i)
        in_own && !count_hit && !frame_rise
        |=> tenure_count_ff == $past(tenure_count_ff) + 8'h01)
        else $error("tenure count did not step");

    count_idle_a: assert property (@(posedge clock_i) disable iff (reset_i)
        state_ff == pcfg_pkg::PCFG_IDLE && !frame_rise
        |=> tenure_count_ff == $past(tenure_count_ff))
        else $error("tenure count moved while idle");

    count_park_a: assert property (@(posedge clock_i) disable iff (reset_i)
        in_expired && !frame_rise |=> tenure_count_ff == $past(tenure_count_ff))
        else $error("tenure count moved after expiry");

    stop_cause_a: assert property (@(posedge clock_i) disable iff (reset_i)
        tenure_stop_o |-> count_hit && grant_lost)
        else $error("tenure stop without cause");

    expire_entry_a: assert property (@(posedge clock_i) disable iff (reset_i)
        in_own && count_hit && !done_sync_ff[1] |=> in_expired)
        else $error("limit reached without expiry");

    limit_zero_a: assert property (@(posedge clock_i) disable iff (reset_i)
        in_own && tenure_limit_ff == 8'h00 && !done_sync_ff[1] |=> in_expired)
        else $error("zero limit did not expire");

    grant_stop_a: assert property (@(posedge clock_i) disable iff (reset_i)
        in_own && count_hit && grant_lost && !done_sync_ff[1] |=> tenure_stop_o || !grant_lost)
        else $error("no stop with grant removed");

    stop_release_a: assert property (@(posedge clock_i) disable iff (reset_i)
        tenure_stop_o |=> state_ff == pcfg_pkg::PCFG_IDLE)
        else $error("tenure not ended after stop");

    done_return_a: assert property (@(posedge clock_i) disable iff (reset_i)
        in_own && done_sync_ff[1] |=> state_ff == pcfg_pkg::PCFG_IDLE)
        else $error("tenure not ended on done");

    line_write_a: assert property (@(posedge clock_i) disable iff (reset_i)
        wr_timing && req_i.byte_en[0] |=> line_length_setting_o == $past(req_i.wdata[7:0]))
        else $error("line length not stored");

    line_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
        !wr_line_en |=> line_length_setting_o == $past(line_length_setting_o))
        else $error("line length changed without write");

    line_read_a: assert property (@(posedge clock_i) disable iff (reset_i)
        rd_req && hit_timing |=> rdata_o[7:0] == $past(line_length_setting_ff))
        else $error("line length read wrong");

    header_zero_a: assert property (@(posedge clock_i) disable iff (reset_i)
        rd_req && hit_timing |=> rdata_o[31:16] == 16'h0000)
        else $error("header or self-test not zero");

    self_test_zero_a: assert property (@(posedge clock_i) disable iff (reset_i)
        rd_req && hit_timing |=> rdata_o[pcfg_pkg::PCFG_TEST_LSB +: 8] == 8'h00)
        else $error("self-test byte not zero");

    header_type_zero_a: assert property (@(posedge clock_i) disable iff (reset_i)
        rd_req && hit_timing |=> rdata_o[23:16] == 8'h00)
        else $error("header type byte not zero");

    ro_write_a: assert property (@(posedge clock_i) disable iff (reset_i)
        wr_class ##[1:4] (rd_req && hit_class)
        |=> rdata_o == {8'h0c, 8'h00, 8'h10, SILICON_STEP})
        else $error("read-only field altered");

    class_write_keep_a: assert property (@(posedge clock_i) disable iff (reset_i)
        wr_class |=> tenure_limit_ff == $past(tenure_limit_ff)
        && line_length_setting_o == $past(line_length_setting_o))
        else $error("class write disturbed settings");

    write_rdata_keep_a: assert property (@(posedge clock_i) disable iff (reset_i)
        req_i.valid && req_i.write |=> rdata_o == $past(rdata_o))
        else $error("write changed read data");

    ack_follow_a: assert property (@(posedge clock_i) disable iff (reset_i)
        req_i.valid |=> ack_o)
        else $error("request not acknowledged");

    ack_origin_a: assert property (@(posedge clock_i) disable iff (reset_i)
        ack_o |-> $past(req_i.valid))
        else $error("acknowledge without request");

endmodule
`default_nettype wire

// >>> bench/pcfg_host_model.sv
// host side model: issues configuration cycles one at a time
// assumes ack_i pulses one cycle after each request is taken
`timescale 1ns/1ps
`default_nettype none
module pcfg_host_model (
    input  wire logic                clock_i,
    input  wire logic                ack_i,
    input  wire logic [31:0]         rdata_i,
    output var pcfg_pkg::pcfg_req_s  req_o
);
    initial req_o = '0;
    task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] rd);
        int n;
        begin
            @(posedge clock_i);
            req_o <= '{valid: 1'b1, write: wr, dword: dw, byte_en: be, wdata: wd};
            @(posedge clock_i);
            // idle bus must not keep showing the last data
            req_o <= '{valid: 1'b0, write: ~wr, dword: ~dw, byte_en: ~be, wdata: ~wd};
            n = 0;
            do begin
                @(posedge clock_i);
                n++;
            end while (ack_i !== 1'b1 && n < 4);
            rd = (ack_i === 1'b1) ? rdata_i : 32'hdead_beef;
        end
    endtask
endmodule
`default_nettype wire

// >>> bench/pcfg_header_test.sv
// self-checking bench for the configuration header slice
// assumes the host model above drives all configuration requests
`timescale 1ns/1ps
`default_nettype none
module pcfg_header_test;
    logic clock_i = 0, reset_i = 1, frame_i = 0, done_i = 0, grant_n = 0, ack, stop;
    logic [31:0] rdata, rd;
    logic [7:0] line_len;
    pcfg_pkg::pcfg_req_s req;
    int errors = 0, checks = 0, cyc = 0, n;
    pcfg_header #(.SILICON_STEP(8'h5a)) u_dut (.clock_i(clock_i), .reset_i(reset_i),
        .req_i(req), .rdata_o(rdata), .ack_o(ack), .frame_start_i(frame_i),
        .xfer_done_i(done_i), .grant_n_i(grant_n), .tenure_stop_o(stop),
        .line_length_setting_o(line_len));
    pcfg_host_model u_host (.clock_i(clock_i), .ack_i(ack), .rdata_i(rdata), .req_o(req));
    always #2 clock_i = ~clock_i;
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic t_ident;
        u_host.access(1'b0, 6'h02, 4'hf, 32'h0, rd);
        check("classification", rd, 32'h0c00_105a);
        u_host.access(1'b0, 6'h03, 4'hf, 32'h0, rd);
        check("timing reset", rd, 32'h0000_0000);
    endtask
    task automatic t_write;
        u_host.access(1'b1, 6'h03, 4'hf, 32'hffff_0420, rd);
        u_host.access(1'b1, 6'h02, 4'hf, 32'h1234_5678, rd);
        u_host.access(1'b0, 6'h02, 4'hf, 32'h0, rd);
        check("class after write", rd, 32'h0c00_105a);
        u_host.access(1'b0, 6'h03, 4'hf, 32'h0, rd);
        check("timing rw", rd, 32'h0000_0420);
        check("line length", {24'h0, line_len}, 32'h0000_0020);
        u_host.access(1'b0, 6'h05, 4'hf, 32'h0, rd);
        check("unmapped", rd, 32'h0);
    endtask
    task automatic t_tenure;
        u_host.access(1'b1, 6'h03, 4'b0010, 32'h0000_1000, rd);
        check("lane write", {24'h0, line_len}, 32'h0000_0020);
        frame_i <= 1;
        repeat (30) @(posedge clock_i);
        check("stop while granted", {31'h0, stop}, 32'h0);
        grant_n <= 1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (stop !== 1'b1 && n < 8);
        check("stop on grant loss", {31'h0, stop}, 32'h1);
        check("grant loss latency", n, 3);
        @(posedge clock_i);
        check("stop one cycle", {31'h0, stop}, 32'h0);
        done_i <= 1;
        frame_i <= 0;
        repeat (6) @(posedge clock_i);
        check("stop after done", {31'h0, stop}, 32'h0);
        done_i <= 0;
        repeat (4) @(posedge clock_i);
        frame_i <= 1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (stop !== 1'b1 && n < 40);
        check("tenure length", n, 21);
    endtask
    task automatic t_reset;
        frame_i <= 0;
        reset_i <= 1;
        repeat (2) @(posedge clock_i);
        reset_i <= 0;
        check("line after reset", {24'h0, line_len}, 32'h0);
        u_host.access(1'b0, 6'h03, 4'hf, 32'h0, rd);
        check("timing after reset", rd, 32'h0000_0000);
    endtask
    initial begin
        repeat (4) @(posedge clock_i);
        reset_i <= 0;
        t_ident();
        t_write();
        t_tenure();
        t_reset();
        wrap_up();
    end
endmodule
`default_nettype wire
